// *** aoc_chk.sv ***
// Assertions on the ports of the upper configuration bank.
// Assumes it is bound to every instance and sees only that instance's ports.
`timescale 1ns/10ps

module aoc_chk
   import aoc_pkg::*;
#(
   parameter int DATA_W = 14
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic custom_pattern_active,
   input wire logic dc_trim_enable,
   input wire logic [DATA_W-1:0] pattern_data,
   input wire logic lvds_selected,
   input wire logic [10:0] rise_advance_ps,
   input wire logic rise_aligned,
   input wire logic fall_aligned,
   input wire logic [10:0] fall_advance_ps,
   input wire logic core_powered_down,
   input wire logic reference_powered_down,
   input wire logic output_pins_enable,
   input wire logic swing_apply,
   input wire logic high_freq_tuning,
   input wire logic loop_run,
   input wire logic hold_offset_estimate,
   input wire logic [4:0] loop_settling_log2,
   input wire logic [DATA_W-1:0] correction_target,
   input wire logic low_speed_enable
);
   localparam int MID = 1 << (DATA_W - 1);

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   a_reset_zero: assert property ($fell(srst) |-> !core_powered_down && output_pins_enable
      && !swing_apply && !high_freq_tuning && !low_speed_enable
      && int'(correction_target) == MID && loop_settling_log2 == 5'h14)
      else $error("bank not cleared by reset");
   a_pattern_idle: assert property (!custom_pattern_active |-> pattern_data == '0)
      else $error("pattern shown while inactive");
   a_loop_follow: assert property (loop_run == dc_trim_enable)
      else $error("loop run differs from enable");
   a_hold_gated: assert property (hold_offset_estimate |-> dc_trim_enable)
      else $error("hold without correction enabled");
   a_ref_down: assert property (reference_powered_down |-> core_powered_down)
      else $error("reference down with core up");
   a_core_pins: assert property (core_powered_down |-> !output_pins_enable)
      else $error("pins on while core down");
   a_rise_align: assert property (rise_aligned |-> lvds_selected && rise_advance_ps == 11'h000)
      else $error("rise aligned outside lvds");
   a_fall_align: assert property (fall_aligned |-> lvds_selected && fall_advance_ps == 11'h000)
      else $error("fall aligned outside lvds");
   a_rise_table: assert property (
      lvds_selected ? rise_advance_ps inside {11'h000, 11'h1f4, 11'h0c8}
      : rise_advance_ps inside {11'h000, 11'h064, 11'h0c8, 11'h5dc})
      else $error("rise advance off table");
   a_settle_min: assert property (loop_settling_log2 >= 5'h14)
      else $error("loop constant below base");
   a_target_span: assert property (int'(correction_target) >= MID - 32
      && int'(correction_target) <= MID + 31) else $error("target outside pedestal span");

   cover property (core_powered_down && reference_powered_down);
   cover property (hold_offset_estimate);
   cover property (rise_aligned);
   cover property (custom_pattern_active && pattern_data != '0);
endmodule

// *** aoc_config_regs.sv ***
// Upper configuration bank of the converter with its serial write port,
// plus the decoding of each field into the controls that it steers.
// Assumes the serial pins are asynchronous to core_clk and run slow
// enough that each serial clock level lasts at least three core cycles.
// The lower-bank inputs (readout, pattern select, correction enable)
// come from logic on core_clk and are read without synchronisers.
//
// Operation
// (RL1) All bank registers reset to zero.
// (RL2) 14-bit: outputs carry full pattern.
// (RL3) 12-bit: outputs carry pattern bits 13:2.
// (RL4) Pattern low byte, high six bits.
// (RL5) Interface code: LVDS, CMOS, else pin.
// (RL6) Clock drive strength, CMOS clock only.
// (RL7) Rise shift only when rise enable set.
// (RL8) LVDS rise shift codes: 500, aligned, 200.
// (RL9) CMOS rise shift codes: 100, 200, 1500.
// (RL10) Fall shift only when fall enable set.
// (RL11) LVDS fall shift codes: 400, aligned, 200.
// (RL12) CMOS fall shift codes: 100, 200, 1500.
// (RL13) Standby: core and buffers off, reference on.
// (RL14) Shutdown: core, references, buffers all off.
// (RL15) Output pins off places pins high-impedance.
// (RL16) Swing applied only for code 11.
// (RL17) Host sets tuning above 230 MHz.
// (RL18) Loop converges to mid-code plus pedestal.
// (RL19) Pedestal is six-bit twos complement.
// (RL20) Hold freezes estimate while correction enabled.
// (RL21) Loop constant is 1M cycles doubled per code.
// (RL22) Low-speed mode only for code 11.
// (RL23) Host writes zero to reserved bits.
// (RL24) Loop runs only while correction enabled.
// (RL25) New settings act after the write completes.
`timescale 1ns/10ps

module aoc_config_regs
   import aoc_pkg::*;
#(
   parameter int DATA_W = 14
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic sen_n,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic readout_enable,
   input wire logic format_select_pin,
   input wire logic custom_pattern_active,
   input wire logic dc_trim_enable,
   output logic sdout,
   output logic [DATA_W-1:0] pattern_data,
   output logic lvds_selected,
   output logic [1:0] parallel_clock_drive_level,
   output logic [10:0] rise_advance_ps,
   output logic rise_aligned,
   output logic [10:0] fall_advance_ps,
   output logic fall_aligned,
   output logic core_powered_down,
   output logic reference_powered_down,
   output logic output_pins_enable,
   output logic swing_apply,
   output logic high_freq_tuning,
   output logic loop_run,
   output logic hold_offset_estimate,
   output logic [4:0] loop_settling_log2,
   output logic [DATA_W-1:0] correction_target,
   output logic low_speed_enable
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      // Pin synchronisers; the third sclk stage only serves edge detection.
      logic sen_s1;
      logic sen_s2;
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_s3;
      logic sdata_s1;
      logic sdata_s2;

      // Frame engine and readback.
      logic [4:0] bit_cnt;
      logic [15:0] shift;
      logic [7:0] rd_shift;
      logic sdout;

      // Register storage, one byte per offset.
      logic [7:0] pat_high;
      logic [7:0] pat_low;
      logic [7:0] if_clk;
      logic [7:0] fall_sleep;
      logic [7:0] power;
      logic [7:0] perf;
      logic [7:0] bias;
      logic [7:0] loop_ctl;
      logic [7:0] reduced;
   } aoc_state_t;

   aoc_state_t state_reg;
   aoc_state_t state_next;

   logic sclk_rise;
   logic sclk_fall;
   logic frame_active;
   logic [15:0] word_in;

   // Returns the current contents of the register at a given offset.
   // Unmapped offsets read as zero, so a host can probe the map safely.
   function automatic logic [7:0] aoc_read(input aoc_state_t s, input logic [7:0] ofs);
      logic [7:0] v;
      v = 8'h00;
      unique case (ofs)
         OFS_PATTERN_HIGH_BITS: v = s.pat_high;
         OFS_PATTERN_LOW_BYTE: v = s.pat_low;
         OFS_OUTPUT_INTERFACE_CLOCK_EDGE_CTRL: v = s.if_clk;
         OFS_FALL_EDGE_AND_STANDBY_CTRL: v = s.fall_sleep;
         OFS_POWER_DOWN_AND_SWING_ENABLE: v = s.power;
         OFS_PERFORMANCE_MODE_TWO: v = s.perf;
         OFS_CONVERGED_CODE_BIAS: v = s.bias;
         OFS_CORRECTION_LOOP_CONTROL: v = s.loop_ctl;
         OFS_REDUCED_RATE_SETTING: v = s.reduced;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------------
   // Serial port and register storage
   // ------------------------------------------------------------------
   // Edges are taken from the second and third stages; the first stage
   // feeds only the second.
   assign sclk_rise = state_reg.sclk_s2 & ~state_reg.sclk_s3;
   assign sclk_fall = ~state_reg.sclk_s2 & state_reg.sclk_s3;
   assign frame_active = ~state_reg.sen_s2;
   assign word_in = {state_reg.shift[14:0], state_reg.sdata_s2};

   // A frame is sixteen rising serial edges, address byte first and most
   // significant bit first. The register is looked up after the eighth
   // edge, so readback is ready before the data byte starts. Raising sen_n
   // clears the bit count, so a cut frame changes no register.
   always_comb begin
      state_next = state_reg;
      state_next.sen_s1 = sen_n;
      state_next.sen_s2 = state_reg.sen_s1;
      state_next.sclk_s1 = sclk;
      state_next.sclk_s2 = state_reg.sclk_s1;
      state_next.sclk_s3 = state_reg.sclk_s2;
      state_next.sdata_s1 = sdata;
      state_next.sdata_s2 = state_reg.sdata_s1;
      if (!frame_active) begin
         state_next.bit_cnt = 5'h00;
         state_next.sdout = 1'b0;
      end else if (sclk_rise && state_reg.bit_cnt < FRAME_BITS) begin
         state_next.shift = word_in;
         state_next.bit_cnt = state_reg.bit_cnt + 5'h01;
         if (state_reg.bit_cnt == ADDR_BITS - 5'h01) begin
            state_next.rd_shift = aoc_read(state_reg, word_in[7:0]);
         end
         // The write lands on the last serial bit, so every decoded field
         // below follows from the next core cycle on.
         if (state_reg.bit_cnt == FRAME_BITS - 5'h01 && !readout_enable) begin // RL25
            unique case (word_in[15:8])
               OFS_PATTERN_HIGH_BITS: begin
                  state_next.pat_high = word_in[7:0]; // RL4
               end
               OFS_PATTERN_LOW_BYTE: begin
                  state_next.pat_low = word_in[7:0]; // RL4
               end
               OFS_OUTPUT_INTERFACE_CLOCK_EDGE_CTRL: begin
                  state_next.if_clk = word_in[7:0];
               end
               OFS_FALL_EDGE_AND_STANDBY_CTRL: begin
                  state_next.fall_sleep = word_in[7:0];
               end
               OFS_POWER_DOWN_AND_SWING_ENABLE: begin
                  state_next.power = word_in[7:0];
               end
               OFS_PERFORMANCE_MODE_TWO: begin
                  state_next.perf = word_in[7:0];
               end
               OFS_CONVERGED_CODE_BIAS: begin
                  state_next.bias = word_in[7:0];
               end
               OFS_CORRECTION_LOOP_CONTROL: begin
                  state_next.loop_ctl = word_in[7:0];
               end
               OFS_REDUCED_RATE_SETTING: begin
                  state_next.reduced = word_in[7:0];
               end
               default: state_next.shift = word_in;
            endcase
         end
      end else if (sclk_fall && readout_enable && state_reg.bit_cnt >= ADDR_BITS
                   && state_reg.bit_cnt < FRAME_BITS) begin
         // Readback goes out MSB first on the falling serial edge, so the
         // host can sample it on the following rising edge.
         state_next.sdout = state_reg.rd_shift[7];
         state_next.rd_shift = {state_reg.rd_shift[6:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         // The port comes out of reset deselected, as if sen_n were high.
         state_reg <= '0;
         state_reg.sen_s1 <= 1'b1;
         state_reg.sen_s2 <= 1'b1;
         state_reg.pat_high <= REG_RESET_VALUE; // RL1
         state_reg.pat_low <= REG_RESET_VALUE; // RL1
         state_reg.if_clk <= REG_RESET_VALUE; // RL1
         state_reg.fall_sleep <= REG_RESET_VALUE; // RL1
         state_reg.power <= REG_RESET_VALUE; // RL1
         state_reg.perf <= REG_RESET_VALUE; // RL1
         state_reg.bias <= REG_RESET_VALUE; // RL1
         state_reg.loop_ctl <= REG_RESET_VALUE; // RL1
         state_reg.reduced <= REG_RESET_VALUE; // RL1
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------------
   // Field decoding
   // ------------------------------------------------------------------
   logic [PATTERN_W-1:0] pattern_full;
   logic [1:0] ifsel;
   logic fmt_pin_s1;
   logic fmt_pin_s2;
   logic [1:0] rise_code;
   logic [1:0] fall_code;
   logic [3:0] settle_code;
   logic signed [PED_W-1:0] pedestal;
   logic [DATA_W-1:0] mid_code;
   logic [DATA_W-1:0] pedestal_ext;

   // The format pin is a board strap, brought in through two stages.
   // The stages reset low, so LVDS stands until the strap is seen.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         fmt_pin_s1 <= 1'b0;
         fmt_pin_s2 <= 1'b0;
      end else begin
         fmt_pin_s1 <= format_select_pin;
         fmt_pin_s2 <= fmt_pin_s1;
      end
   end

   assign sdout = state_reg.sdout;

   assign pattern_full = {state_reg.pat_high[PAT_HIGH_HI:0], state_reg.pat_low}; // RL4
   // A narrower variant keeps the top bits and drops the low ones.
   always_comb begin
      if (custom_pattern_active) begin
         pattern_data = pattern_full[PATTERN_W-1 -: DATA_W]; // RL2 RL3
      end else begin
         pattern_data = '0;
      end
   end

   assign ifsel = state_reg.if_clk[IFSEL_HI:IFSEL_LO];
   always_comb begin
      if (ifsel == IFSEL_LVDS) begin
         lvds_selected = 1'b1; // RL5
      end else if (ifsel == IFSEL_CMOS) begin
         lvds_selected = 1'b0; // RL5
      end else begin
         lvds_selected = ~fmt_pin_s2; // RL5
      end
   end

   // Strength matters only to the parallel clock driver; LVDS ignores it.
   assign parallel_clock_drive_level = state_reg.if_clk[DRIVE_HI:DRIVE_LO]; // RL6

   always_comb begin
      rise_code = SHIFT_DEFAULT; // RL7
      fall_code = SHIFT_DEFAULT; // RL10
      if (state_reg.if_clk[RISE_EN_BIT]) begin
         rise_code = state_reg.if_clk[RISE_HI:RISE_LO]; // RL7
      end
      if (state_reg.if_clk[FALL_EN_BIT]) begin
         fall_code = state_reg.fall_sleep[FALL_HI:FALL_LO]; // RL10
      end
   end

   // LVDS code 10 aligns the edge with data and carries no advance.
   always_comb begin
      rise_aligned = 1'b0;
      fall_aligned = 1'b0;
      rise_advance_ps = 11'd0;
      fall_advance_ps = 11'd0;
      if (lvds_selected) begin
         unique case (rise_code)
            SHIFT_DEFAULT: rise_advance_ps = 11'd0;
            SHIFT_CODE_1: rise_advance_ps = RISE_LVDS_CODE1_PS; // RL8
            SHIFT_CODE_2: rise_aligned = 1'b1; // RL8
            default: rise_advance_ps = LVDS_CODE3_PS; // RL8
         endcase

         unique case (fall_code)
            SHIFT_DEFAULT: fall_advance_ps = 11'd0;
            SHIFT_CODE_1: fall_advance_ps = FALL_LVDS_CODE1_PS; // RL11
            SHIFT_CODE_2: fall_aligned = 1'b1; // RL11
            default: fall_advance_ps = LVDS_CODE3_PS; // RL11
         endcase
      end else begin
         unique case (rise_code)
            SHIFT_DEFAULT: rise_advance_ps = 11'd0;
            SHIFT_CODE_1: rise_advance_ps = CMOS_CODE1_PS; // RL9
            SHIFT_CODE_2: rise_advance_ps = CMOS_CODE2_PS; // RL9
            default: rise_advance_ps = CMOS_CODE3_PS; // RL9
         endcase

         unique case (fall_code)
            SHIFT_DEFAULT: fall_advance_ps = 11'd0;
            SHIFT_CODE_1: fall_advance_ps = CMOS_CODE1_PS; // RL12
            SHIFT_CODE_2: fall_advance_ps = CMOS_CODE2_PS; // RL12
            default: fall_advance_ps = CMOS_CODE3_PS; // RL12
         endcase
      end
   end

   // Standby keeps the reference alive for fast wake-up; shutdown does not.
   always_comb begin
      core_powered_down = 1'b0;
      if (state_reg.fall_sleep[SLEEP_BIT]) begin
         core_powered_down = 1'b1; // RL13
      end
      if (state_reg.power[SHUTDOWN_BIT]) begin
         core_powered_down = 1'b1; // RL14
      end
   end
   assign reference_powered_down = state_reg.power[SHUTDOWN_BIT]; // RL14
   assign output_pins_enable = ~(state_reg.power[PINS_OFF_BIT] | core_powered_down); // RL15

   // Codes 01 and 10 are forbidden to the host and treated as off.
   always_comb begin
      swing_apply = 1'b0;
      if (state_reg.power[SWING_HI:SWING_LO] == FIELD_ON) begin
         swing_apply = 1'b1; // RL16
      end
   end

   assign high_freq_tuning = state_reg.perf[HF_TUNING_BIT];

   always_comb begin
      low_speed_enable = 1'b0;
      if (state_reg.reduced[REDUCED_HI:REDUCED_LO] == FIELD_ON) begin
         low_speed_enable = 1'b1; // RL22
      end
   end

   // A freeze means nothing while the loop is off, so hold is gated too.
   assign loop_run = dc_trim_enable; // RL24
   assign hold_offset_estimate = dc_trim_enable & state_reg.loop_ctl[HOLD_BIT]; // RL20

   // Codes above the last listed one saturate at the longest constant.
   assign settle_code = state_reg.loop_ctl[SETTLE_HI:SETTLE_LO];
   always_comb begin
      if (settle_code > SETTLE_CODE_MAX) begin
         loop_settling_log2 = SETTLE_LOG2_BASE + {1'b0, SETTLE_CODE_MAX}; // RL21
      end else begin
         loop_settling_log2 = SETTLE_LOG2_BASE + {1'b0, settle_code}; // RL21
      end
   end

   assign pedestal = state_reg.bias[PED_HI:PED_LO]; // RL19
   // Mid-code is the top bit alone; the pedestal is sign-extended onto it.
   assign mid_code = {1'b1, {(DATA_W-1){1'b0}}};
   assign pedestal_ext = DATA_W'({{(DATA_W-PED_W){pedestal[PED_W-1]}}, pedestal}); // RL19
   assign correction_target = mid_code + pedestal_ext; // RL18

endmodule

// *** aoc_config_regs_tb.sv ***
// Self-checking bench for the upper configuration bank, 14-bit and 12-bit.
// Assumes the host model frames every register access.
`timescale 1ns/10ps

module aoc_config_regs_tb;
   import aoc_pkg::*;
   logic core_clk, srst, sen_n, sclk, sdata, readout_enable, format_select_pin;
   logic custom_pattern_active, dc_trim_enable, sdout, lvds_selected, rise_aligned;
   logic fall_aligned, core_powered_down, reference_powered_down, output_pins_enable;
   logic swing_apply, high_freq_tuning, loop_run, hold_offset_estimate, low_speed_enable;
   logic [13:0] pattern_data, correction_target;
   logic [11:0] p12;
   logic [1:0] parallel_clock_drive_level;
   logic [10:0] rise_advance_ps, fall_advance_ps;
   logic [4:0] loop_settling_log2;
   int mismatches = 0;
   int check_count = 0;

   aoc_config_regs #(.DATA_W(14)) i_aoc_config_regs (.*);
   aoc_config_regs #(.DATA_W(12)) i_aoc_config_regs_12 (.core_clk, .srst, .sen_n, .sclk,
      .sdata, .readout_enable, .format_select_pin, .custom_pattern_active, .dc_trim_enable,
      .sdout(), .pattern_data(p12), .lvds_selected(), .parallel_clock_drive_level(),
      .rise_advance_ps(), .rise_aligned(), .fall_advance_ps(), .fall_aligned(),
      .core_powered_down(), .reference_powered_down(), .output_pins_enable(),
      .swing_apply(), .high_freq_tuning(), .loop_run(), .hold_offset_estimate(),
      .loop_settling_log2(), .correction_target(), .low_speed_enable());
   aoc_host i_aoc_host (.core_clk, .sdout, .sen_n, .sclk, .sdata);

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      i_aoc_host.xfer(a, d, q);
      repeat (6) @(posedge core_clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge core_clk) #1 readout_enable = 1'b1;
      i_aoc_host.xfer(a, 8'hff, q);
      repeat (6) @(posedge core_clk);
      #1 readout_enable = 1'b0;
   endtask

   function automatic logic [10:0] ps(input logic lv, input logic fl, input logic [1:0] c);
      case (c)
         2'h1: ps = lv ? (fl ? 11'h190 : 11'h1f4) : 11'h064;
         2'h2: ps = lv ? 11'h000 : 11'h0c8;
         2'h3: ps = lv ? 11'h0c8 : 11'h5dc;
         default: ps = 11'h000;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] q;
      logic [7:0] ofs[10] = '{8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h4a, 8'hbf, 8'hcf, 8'hdf,
         8'h55};
      foreach (ofs[i]) begin
         rd(ofs[i], q);
         chk("reset_value", 16'h0000, q);
      end
      chk("read_no_write", 16'h0000, core_powered_down);
   endtask

   task automatic t_pattern();
      logic [7:0] q;
      wr(8'h3f, 8'h2a);
      wr(8'h40, 8'hc5);
      @(posedge core_clk) #1 custom_pattern_active = 1'b1;
      @(posedge core_clk) #1;
      chk("pattern14", 16'h2ac5, pattern_data);
      chk("pattern12", 16'h0ab1, p12);
      rd(8'h3f, q);
      chk("pattern_high", 16'h002a, q);
      @(posedge core_clk) #1 custom_pattern_active = 1'b0;
   endtask

   task automatic t_iface();
      for (int c = 0; c < 4; c++)
         for (int p = 0; p < 2; p++) begin
            @(posedge core_clk) #1 format_select_pin = p[0];
            wr(8'h41, {c[1:0], c[1:0], 4'h0});
            chk("lvds_sel", 16'((c == 1) || (!c[0] && !p[0])), lvds_selected);
            chk("drive", 16'(c[1:0]), parallel_clock_drive_level);
         end
   endtask

   task automatic t_edges();
      logic lv;
      for (int m = 0; m < 2; m++)
         for (int c = 0; c < 4; c++)
            for (int e = 0; e < 2; e++) begin
               lv = (m == 0);
               wr(8'h41, {(lv ? 2'h1 : 2'h3), 2'h0, e[0], c[1:0], e[0]});
               wr(8'h42, {c[1:0], 6'h00});
               chk("rise_ps", 16'(e[0] ? ps(lv, 1'b0, c[1:0]) : 11'h000), rise_advance_ps);
               chk("fall_ps", 16'(e[0] ? ps(lv, 1'b1, c[1:0]) : 11'h000), fall_advance_ps);
               chk("rise_al", 16'(e[0] && lv && c == 2), rise_aligned);
               chk("fall_al", 16'(e[0] && lv && c == 2), fall_aligned);
            end
   endtask

   task automatic t_power();
      logic [19:0] tb[6] = '{{8'h42, 8'h04, 4'h8}, {8'h42, 8'h00, 4'h2}, {8'h43, 8'h40, 4'hc},
         {8'h43, 8'h10, 4'h0}, {8'h43, 8'h03, 4'h3}, {8'h43, 8'h00, 4'h2}};
      foreach (tb[i]) begin
         wr(tb[i][19:12], tb[i][11:4]);
         chk("power", 16'(tb[i][3:0]), {core_powered_down, reference_powered_down,
            output_pins_enable, swing_apply});
      end
   endtask

   task automatic t_misc();
      wr(8'h4a, 8'h01);
      chk("hf_tuning", 16'h0001, high_freq_tuning);
      wr(8'hdf, 8'h30);
      chk("low_speed", 16'h0001, low_speed_enable);
      wr(8'hdf, 8'h20);
      chk("low_speed", 16'h0000, low_speed_enable);
      wr(8'hbf, 8'h80);
      chk("target", 16'h1fe0, correction_target);
      wr(8'hbf, 8'h7c);
      chk("target", 16'h201f, correction_target);
      for (int t = 0; t < 2; t++) begin
         @(posedge core_clk) #1 dc_trim_enable = t[0];
         wr(8'hcf, 8'hac);
         chk("hold", 16'(t[0]), hold_offset_estimate);
         chk("loop_run", 16'(t[0]), loop_run);
         chk("settle", 16'h001f, loop_settling_log2);
      end
      wr(8'hcf, 8'h00);
      chk("hold", 16'h0000, hold_offset_estimate);
      chk("settle", 16'h0014, loop_settling_log2);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      finish_test();
   end

   initial begin
      srst = 1'b1;
      readout_enable = 1'b0;
      format_select_pin = 1'b0;
      custom_pattern_active = 1'b0;
      dc_trim_enable = 1'b0;
      repeat (16) @(posedge core_clk);
      #1 srst = 1'b0;
      t_reset();
      t_pattern();
      t_iface();
      t_edges();
      t_power();
      t_misc();
      finish_test();
   end
endmodule

bind aoc_config_regs aoc_chk #(.DATA_W(DATA_W)) i_aoc_chk (.core_clk, .srst,
   .custom_pattern_active, .dc_trim_enable, .pattern_data, .lvds_selected, .rise_advance_ps,
   .rise_aligned, .fall_aligned, .fall_advance_ps, .core_powered_down, .reference_powered_down,
   .output_pins_enable, .swing_apply, .high_freq_tuning, .loop_run, .hold_offset_estimate,
   .loop_settling_log2, .correction_target, .low_speed_enable);

// *** aoc_host.sv ***
// Host model that drives the serial configuration port.
// Assumes each sclk level may last several core_clk cycles.
`timescale 1ns/10ps

module aoc_host (
   input wire logic core_clk,
   input wire logic sdout,
   output logic sen_n,
   output logic sclk,
   output logic sdata
);
   initial begin
      sen_n = 1'b1;
      sclk = 1'b0;
      sdata = 1'b0;
   end

   // One frame: address then data, most significant bit first.
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [15:0] f;
      f = {a, d};
      q = 8'h00;
      @(posedge core_clk) #1 sen_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge core_clk) #1 sdata = f[i];
         repeat (5) @(posedge core_clk);
         #1;
         if (i < 8) begin
            q = {q[6:0], sdout};
         end
         sclk = 1'b1;
         repeat (4) @(posedge core_clk);
         #1 sclk = 1'b0;
      end
      repeat (6) @(posedge core_clk);
      #1 sen_n = 1'b1;
      // A released line has no pull; show the inverse so nothing relies on it.
      sdata = ~sdata;
   endtask
endmodule

// *** aoc_pkg.sv ***
// Constants for the upper configuration bank of the converter: offsets,
// field positions, codes and edge-shift figures.
// Assumes the serial port frames are 8 address bits then 8 data bits.
package aoc_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_PATTERN_HIGH_BITS = 8'h3f;
   localparam logic [7:0] OFS_PATTERN_LOW_BYTE = 8'h40;
   localparam logic [7:0] OFS_OUTPUT_INTERFACE_CLOCK_EDGE_CTRL = 8'h41;
   localparam logic [7:0] OFS_FALL_EDGE_AND_STANDBY_CTRL = 8'h42;
   localparam logic [7:0] OFS_POWER_DOWN_AND_SWING_ENABLE = 8'h43;
   localparam logic [7:0] OFS_PERFORMANCE_MODE_TWO = 8'h4a;
   localparam logic [7:0] OFS_CONVERGED_CODE_BIAS = 8'hbf;
   localparam logic [7:0] OFS_CORRECTION_LOOP_CONTROL = 8'hcf;
   localparam logic [7:0] OFS_REDUCED_RATE_SETTING = 8'hdf;
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int IFSEL_HI = 7;
   localparam int IFSEL_LO = 6;
   localparam int DRIVE_HI = 5;
   localparam int DRIVE_LO = 4;
   localparam int RISE_EN_BIT = 3;
   localparam int RISE_HI = 2;
   localparam int RISE_LO = 1;
   localparam int FALL_EN_BIT = 0;
   localparam int FALL_HI = 7;
   localparam int FALL_LO = 6;
   localparam int SLEEP_BIT = 2;
   localparam int SHUTDOWN_BIT = 6;
   localparam int PINS_OFF_BIT = 4;
   localparam int SWING_HI = 1;
   localparam int SWING_LO = 0;
   localparam int HF_TUNING_BIT = 0;
   localparam int PED_HI = 7;
   localparam int PED_LO = 2;
   localparam int HOLD_BIT = 7;
   localparam int SETTLE_HI = 5;
   localparam int SETTLE_LO = 2;
   localparam int REDUCED_HI = 5;
   localparam int REDUCED_LO = 4;
   localparam int PAT_HIGH_HI = 5;
   localparam int PATTERN_W = 14;
   localparam int PED_W = 6;

   // ------------------------------------------------------------------
   // Codes
   // ------------------------------------------------------------------
   localparam logic [1:0] IFSEL_LVDS = 2'h1;
   localparam logic [1:0] IFSEL_CMOS = 2'h3;
   localparam logic [1:0] FIELD_ON = 2'h3;
   localparam logic [1:0] SHIFT_DEFAULT = 2'h0;
   localparam logic [1:0] SHIFT_CODE_1 = 2'h1;
   localparam logic [1:0] SHIFT_CODE_2 = 2'h2;
   localparam logic [3:0] SETTLE_CODE_MAX = 4'hb;
   localparam logic [4:0] SETTLE_LOG2_BASE = 5'h14;

   // ------------------------------------------------------------------
   // Edge advance in picoseconds
   // ------------------------------------------------------------------
   localparam logic [10:0] RISE_LVDS_CODE1_PS = 11'd500;
   localparam logic [10:0] FALL_LVDS_CODE1_PS = 11'd400;
   localparam logic [10:0] LVDS_CODE3_PS = 11'd200;
   localparam logic [10:0] CMOS_CODE1_PS = 11'd100;
   localparam logic [10:0] CMOS_CODE2_PS = 11'd200;
   localparam logic [10:0] CMOS_CODE3_PS = 11'd1500;

   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] ADDR_BITS = 5'h08;

endpackage
